// file: inc/cssc_consts.vh
`ifndef CSSC_CONSTS_VH
`define CSSC_CONSTS_VH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CSSC_OFS_OSC      8'h00
`define CSSC_OFS_STAT     8'h04
`define CSSC_OFS_CTRL     8'h08
`define CSSC_OFS_PSAV     8'h0c
// ****************************************
// Oscillator control field positions
// ****************************************
`define CSSC_CUR_HI       14
`define CSSC_CUR_LO       12
`define CSSC_NEW_HI       10
`define CSSC_NEW_LO       8
`define CSSC_LOCK_BIT     5
`define CSSC_FAIL_BIT     3
`define CSSC_SWREQ_BIT    0
// ****************************************
// Unlock keys
// ****************************************
`define CSSC_KEY_H1       8'h78
`define CSSC_KEY_H2       8'h9a
`define CSSC_KEY_L1       8'h46
`define CSSC_KEY_L2       8'h57
// ****************************************
// Source codes
// ****************************************
`define CSSC_SRC_FRC      3'h0
`define CSSC_SRC_FAST_RC_MULTIPLIED_MODE   3'h1
`define CSSC_SRC_PRI      3'h2
`define CSSC_SRC_PRIPLL   3'h3
`define CSSC_SRC_SEC      3'h4
`define CSSC_SRC_LOW_POWER_RC_OSC     3'h5
// ****************************************
// Timing and reset values
// ****************************************
`define CSSC_SETTLE_CYC   4'ha
`define CSSC_CTRL_RST     8'h00
`endif

// file: hw/cssc_clock_switch_ctrl.v
// Summary of operation
// RQ1: Switching allowed only with config bit low
// RQ2: Disabled: new field ignored, request held zero
// RQ3: High byte unlocked by 78h then 9Ah
// RQ4: Low byte unlocked by 46h then 57h
// RQ5: Software keeps interrupts off while unlocking
// RQ6: Equal sources: request cleared, switch aborted
// RQ7: Valid switch clears lock and fail flags
// RQ8: Start source, wait startup timer or lock
// RQ9: Count ten new-source cycles before changeover
// RQ10: Changeover clears request, copies new to current
// RQ11: Old source off unless retained exceptions
// RQ12: Processor keeps running during the switch
// RQ13: Software routes multiplied switches through fast RC
// RQ14: Software polls request bit then lock bit
// RQ15: Power-save selects Sleep or Idle
// RQ16: Enabled interrupt, reset or watchdog wakes
// RQ17: Sleep stops system clock, monitor, peripherals
// RQ18: Low-power RC kept for watchdog or monitor; code keeps it in Sleep for watchdog only, in run mode only after a switch
// RQ19: Watchdog cleared on Sleep or Idle entry
// RQ20: Sleep wake resumes same clock source
// RQ21: Idle wake reapplies processor clock immediately
// RQ22: Coincident interrupt deferred until entry completes
// RQ23: Broken key pair keeps the byte locked
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`include "cssc_consts.vh"
module cssc_clock_switch_ctrl (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  input  wire        clock_switch_cfg_bit_i,
  input  wire [2:0]  default_source_cfg_i,
  input  wire        secondary_osc_enable_i,
  input  wire        watchdog_enable_i,
  input  wire        crystal_startup_done_i,
  input  wire        pll_lock_i,
  input  wire        new_src_tick_i,
  input  wire        clock_fail_i,
  input  wire        irq_pending_i,
  input  wire        wdt_timeout_i,
  output reg  [5:0]  osc_enable_o,
  output reg  [2:0]  sys_clk_sel_o,
  output reg         cpu_clk_en_o,
  output reg         sys_clk_en_o,
  output reg         fail_safe_active_o,
  output reg         wdt_clear_o,
  output reg         switch_busy_o
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  reg [6:0] meta_r;
  reg [6:0] sync_r;
  always @(posedge clk_i) begin
    meta_r <= {clock_switch_cfg_bit_i, secondary_osc_enable_i, watchdog_enable_i,
               crystal_startup_done_i, pll_lock_i, new_src_tick_i, clock_fail_i};
    sync_r <= meta_r;
  end
  wire cfg_dis_s = sync_r[6];
  wire sec_en_s  = sync_r[5];
  wire wdt_en_s  = sync_r[4];
  wire ost_s     = sync_r[3];
  wire lock_s    = sync_r[2];
  wire tick_s    = sync_r[1];
  wire fail_s    = sync_r[0];
  reg  tick_d_r;
  wire tick_rise = tick_s & ~tick_d_r;
  wire sw_en     = ~cfg_dis_s; //RQ1

  // ****************************************
  // Helpers
  // ****************************************
  function is_pll;
    input [2:0] s;
    begin
      is_pll = (s == `CSSC_SRC_FAST_RC_MULTIPLIED_MODE) || (s == `CSSC_SRC_PRIPLL);
    end
  endfunction
  function is_xtal;
    input [2:0] s;
    begin
      is_xtal = (s == `CSSC_SRC_PRI) || (s == `CSSC_SRC_PRIPLL);
    end
  endfunction
  function [5:0] src_onehot;
    input [2:0] s;
    begin
      src_onehot = 6'h01 << s;
    end
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  wire bus_req = cyc_i & stb_i & ~ack_o;
  wire wr      = bus_req & we_i;
  wire wr_osc  = wr & (adr_i == `CSSC_OFS_OSC);
  wire wr_hi   = wr_osc & sel_i[1];
  wire wr_lo   = wr_osc & sel_i[0];
  wire wr_psav = wr & (adr_i == `CSSC_OFS_PSAV) & sel_i[0];
  wire wr_ctrl = wr & (adr_i == `CSSC_OFS_CTRL) & sel_i[0];

  // ****************************************
  // Unlock sequencer
  // ****************************************
  localparam UL_IDLE = 2'h0;
  localparam UL_KEY1 = 2'h1;
  localparam UL_OPEN = 2'h2;
  reg [1:0] ulh_r;
  reg [1:0] ull_r;
  reg [1:0] ulh_nxt;
  reg [1:0] ull_nxt;
  reg       osc_wr_d_r;
  wire      hi_open = (ulh_r == UL_OPEN);
  wire      lo_open = (ull_r == UL_OPEN);
  always @* begin
    ulh_nxt = ulh_r;
    if (wr_osc) begin //RQ23
      case (ulh_r)
        UL_IDLE: ulh_nxt = (wr_hi && dat_i[15:8] == `CSSC_KEY_H1) ? UL_KEY1 : UL_IDLE;
        UL_KEY1: ulh_nxt = (wr_hi && dat_i[15:8] == `CSSC_KEY_H2) ? UL_OPEN : UL_IDLE; //RQ3
        UL_OPEN: ulh_nxt = UL_IDLE;
        default: ulh_nxt = UL_IDLE;
      endcase
    end
    ull_nxt = ull_r;
    if (wr_osc) begin
      case (ull_r)
        UL_IDLE: ull_nxt = (wr_lo && dat_i[7:0] == `CSSC_KEY_L1) ? UL_KEY1 : UL_IDLE;
        UL_KEY1: ull_nxt = (wr_lo && dat_i[7:0] == `CSSC_KEY_L2) ? UL_OPEN : UL_IDLE; //RQ4
        UL_OPEN: ull_nxt = UL_IDLE;
        default: ull_nxt = UL_IDLE;
      endcase
    end
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      ulh_r <= UL_IDLE;
      ull_r <= UL_IDLE;
    end else begin
      ulh_r <= ulh_nxt;
      ull_r <= ull_nxt;
    end
  end

  // ****************************************
  // Switch state machine
  // ****************************************
  localparam SW_IDLE   = 3'h0;
  localparam SW_CHECK  = 3'h1;
  localparam SW_START  = 3'h2;
  localparam SW_SETTLE = 3'h3;
  localparam SW_SWAP   = 3'h4;
  reg [2:0] sw_r;
  reg [2:0] cur_src_r;
  reg [2:0] new_src_r;
  reg       swreq_r;
  reg       lock_r;
  reg       fail_r;
  reg [3:0] settle_r;
  reg [5:0] osc_on_r;
  reg       sleep_r;
  reg       idle_r;
  reg       psav_pend_r;
  reg       psav_mode_r;
  reg [7:0] irq_en_r;
  wire [2:0] cur_view = sw_en ? cur_src_r : default_source_cfg_i; //RQ2
  wire      new_ready = is_pll(new_src_r) ? lock_s :
                        (is_xtal(new_src_r) ? ost_s : 1'b1); //RQ8
  wire      keep_low_power_rc_osc = wdt_en_s | sw_en;
  always @(posedge clk_i) begin
    tick_d_r <= tick_s;
    if (rst_i) begin
      sw_r      <= SW_IDLE;
      cur_src_r <= `CSSC_SRC_FRC;
      new_src_r <= `CSSC_SRC_FRC;
      swreq_r   <= 1'b0;
      lock_r    <= 1'b0;
      fail_r    <= 1'b0;
      settle_r  <= 4'h0;
      osc_on_r  <= 6'h00;
    end else begin
      lock_r <= is_pll(cur_src_r) | is_pll(new_src_r) ? lock_s : lock_r;
      if (fail_s && sw_en)
        fail_r <= 1'b1;
      if (!sw_en) begin
        cur_src_r <= default_source_cfg_i; //RQ2
        swreq_r   <= 1'b0;
        sw_r      <= SW_IDLE;
        osc_on_r  <= src_onehot(default_source_cfg_i);
      end else begin
        if (wr_hi && hi_open && sw_r == SW_IDLE)
          new_src_r <= dat_i[`CSSC_NEW_HI:`CSSC_NEW_LO];
        if (wr_lo && lo_open && dat_i[`CSSC_SWREQ_BIT] && sw_r == SW_IDLE)
          swreq_r <= 1'b1;
        if (wr_lo && lo_open && !fail_s)
          fail_r <= dat_i[`CSSC_FAIL_BIT];
        case (sw_r)
          SW_IDLE: if (swreq_r) sw_r <= SW_CHECK;
          SW_CHECK: begin
            if (new_src_r == cur_src_r) begin //RQ6
              swreq_r <= 1'b0;
              sw_r    <= SW_IDLE;
            end else begin
              lock_r <= 1'b0; //RQ7
              fail_r <= 1'b0;
              sw_r   <= SW_START;
            end
          end
          SW_START: begin
            osc_on_r <= osc_on_r | src_onehot(new_src_r); //RQ8
            if (new_ready) begin
              settle_r <= 4'h0;
              sw_r     <= SW_SETTLE;
            end
          end
          SW_SETTLE: begin
            if (tick_rise)
              settle_r <= settle_r + 4'h1; //RQ9
            if (settle_r == `CSSC_SETTLE_CYC)
              sw_r <= SW_SWAP;
          end
          SW_SWAP: begin
            swreq_r   <= 1'b0; //RQ10
            cur_src_r <= new_src_r;
            osc_on_r  <= src_onehot(new_src_r) |
                         (keep_low_power_rc_osc ? src_onehot(`CSSC_SRC_LOW_POWER_RC_OSC) : 6'h00) |
                         (sec_en_s ? src_onehot(`CSSC_SRC_SEC) : 6'h00); //RQ11
            sw_r      <= SW_IDLE;
          end
          default: sw_r <= SW_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Power-save modes
  // ****************************************
  wire wake = (irq_pending_i & irq_en_r[0]) | wdt_timeout_i; //RQ16
  always @(posedge clk_i) begin
    if (rst_i) begin //RQ16
      sleep_r     <= 1'b0;
      idle_r      <= 1'b0;
      psav_pend_r <= 1'b0;
      psav_mode_r <= 1'b0;
      irq_en_r    <= `CSSC_CTRL_RST;
      wdt_clear_o <= 1'b0;
    end else begin
      wdt_clear_o <= 1'b0;
      if (wr_ctrl)
        irq_en_r <= dat_i[7:0];
      if (wr_psav && !sleep_r && !idle_r) begin //RQ15
        psav_pend_r <= 1'b1;
        psav_mode_r <= dat_i[0];
      end
      if (psav_pend_r) begin //RQ22
        psav_pend_r <= 1'b0;
        sleep_r     <= ~psav_mode_r;
        idle_r      <= psav_mode_r;
        wdt_clear_o <= wdt_en_s; //RQ19
      end else if ((sleep_r || idle_r) && wake) begin
        sleep_r <= 1'b0; //RQ20
        idle_r  <= 1'b0; //RQ21
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      osc_enable_o       <= 6'h00;
      sys_clk_sel_o      <= `CSSC_SRC_FRC;
      cpu_clk_en_o       <= 1'b1;
      sys_clk_en_o       <= 1'b1;
      fail_safe_active_o <= 1'b0;
      switch_busy_o      <= 1'b0;
    end else begin
      if (sleep_r) //RQ17
        osc_enable_o <= wdt_en_s ? src_onehot(`CSSC_SRC_LOW_POWER_RC_OSC) : 6'h00; //RQ18
      else if (idle_r)
        osc_enable_o <= osc_on_r | (keep_low_power_rc_osc ? src_onehot(`CSSC_SRC_LOW_POWER_RC_OSC) : 6'h00);
      else
        osc_enable_o <= osc_on_r;
      sys_clk_sel_o      <= cur_view; //RQ20
      cpu_clk_en_o       <= ~(sleep_r | idle_r); //RQ12
      sys_clk_en_o       <= ~sleep_r; //RQ17
      fail_safe_active_o <= sw_en & ~sleep_r; //RQ1
      switch_busy_o      <= (sw_r != SW_IDLE);
    end
  end

  // ****************************************
  // Bus read and acknowledge
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
        case (adr_i)
          `CSSC_OFS_OSC: dat_o <= {17'h0, cur_view, 1'b0, new_src_r, 2'h0,
                                   lock_r, 1'b0, fail_r, 2'h0, swreq_r};
          `CSSC_OFS_STAT: dat_o <= {24'h000000, switch_busy_o, sleep_r, idle_r,
                                    sw_en, 1'b0, sw_r};
          `CSSC_OFS_CTRL: dat_o <= {24'h000000, irq_en_r};
          `CSSC_OFS_PSAV: dat_o <= {31'h0, psav_mode_r};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// file: tb/cssc_chk_sva.sv
`timescale 1ns/1ns
module cssc_chk (
  input wire       clk_i,
  input wire       rst_i,
  input wire       cyc_i,
  input wire       stb_i,
  input wire       ack_o,
  input wire       clock_switch_cfg_bit_i,
  input wire       wdt_timeout_i,
  input wire [5:0] osc_enable_o,
  input wire [2:0] sys_clk_sel_o,
  input wire       cpu_clk_en_o,
  input wire       sys_clk_en_o,
  input wire       fail_safe_active_o,
  input wire       wdt_clear_o,
  input wire       switch_busy_o
);
  // ****
  // Port checks
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence bus_req; cyc_i && stb_i && !ack_o; endsequence
  sequence ack_once; ack_o ##1 !ack_o; endsequence
  bus_ack_a: assert property (bus_req |=> ack_once)
    else $error("bus ack missing or long");
  sw_disabled_a: assert property (
    clock_switch_cfg_bit_i [*6] |-> !fail_safe_active_o && !switch_busy_o)
    else $error("switch logic active while disabled");
  sel_swap_a: assert property (
    $changed(sys_clk_sel_o) |-> $past(switch_busy_o) || $past(switch_busy_o, 2))
    else $error("clock select moved outside a switch");
  old_off_a: assert property (
    $changed(sys_clk_sel_o) && $past(sys_clk_sel_o) == 3'h0 |-> ##[0:2] !osc_enable_o[0])
    else $error("old source left running");
  cpu_runs_a: assert property ($rose(switch_busy_o) |-> cpu_clk_en_o)
    else $error("cpu stopped by switch");
  sleep_off_a: assert property (
    !sys_clk_en_o |-> !cpu_clk_en_o && !fail_safe_active_o && $stable(sys_clk_sel_o))
    else $error("sleep state inconsistent");
  wdt_clear_a: assert property (
    wdt_clear_o |-> ##[0:1] !cpu_clk_en_o ##1 !wdt_clear_o)
    else $error("watchdog clear not at entry");
  wake_sleep_a: assert property (
    !sys_clk_en_o && wdt_timeout_i |-> ##[1:4] sys_clk_en_o && cpu_clk_en_o)
    else $error("no wake from sleep");
  wake_idle_a: assert property (
    sys_clk_en_o && !cpu_clk_en_o && wdt_timeout_i |-> ##[1:4] cpu_clk_en_o)
    else $error("no wake from idle");
endmodule

// file: tb/cssc_osc_model.sv
`timescale 1ns/1ns
module cssc_osc_model (
  input  wire logic       clk_i,
  input  wire logic [5:0] osc_enable_i,
  input  wire logic       run_i,
  output logic            crystal_startup_done_o,
  output logic            pll_lock_o,
  output logic            new_src_tick_o
);
  // ****
  // Oscillator sources
  // ****
  logic [5:0] xcnt_r = 6'h00;
  logic [1:0] ph_r = 2'h0;
  always @(posedge clk_i) begin
    xcnt_r <= (osc_enable_i[2] | osc_enable_i[3]) ? xcnt_r + {5'h00, ~&xcnt_r} : 6'h00;
    ph_r <= run_i ? ph_r + 2'h1 : 2'h0;
  end
  assign crystal_startup_done_o = &xcnt_r;
  assign pll_lock_o = osc_enable_i[1] | osc_enable_i[3];
  assign new_src_tick_o = ph_r[1];
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ns
`include "cssc_consts.vh"
module testbench;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, run = 0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic        ack_o, clock_switch_cfg_bit_i = 1, secondary_osc_enable_i = 0;
  logic        watchdog_enable_i = 1, crystal_startup_done_i, pll_lock_i, new_src_tick_i;
  logic        clock_fail_i = 0, irq_pending_i = 0, wdt_timeout_i = 0;
  logic [2:0]  default_source_cfg_i = 3'h0, sys_clk_sel_o;
  logic [5:0]  osc_enable_o;
  logic        cpu_clk_en_o, sys_clk_en_o, fail_safe_active_o, wdt_clear_o, switch_busy_o;
  logic        seen_clr = 0, seen_idle = 0;
  int          fail_count = 0, comparisons = 0;
  // ****
  // Design and far side
  // ****
  cssc_clock_switch_ctrl u_cssc_clock_switch_ctrl (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .clock_switch_cfg_bit_i, .default_source_cfg_i,
    .secondary_osc_enable_i, .watchdog_enable_i, .crystal_startup_done_i, .pll_lock_i,
    .new_src_tick_i, .clock_fail_i, .irq_pending_i, .wdt_timeout_i, .osc_enable_o,
    .sys_clk_sel_o, .cpu_clk_en_o, .sys_clk_en_o, .fail_safe_active_o, .wdt_clear_o,
    .switch_busy_o);
  cssc_osc_model u_cssc_osc_model (.clk_i, .osc_enable_i(osc_enable_o), .run_i(run),
    .crystal_startup_done_o(crystal_startup_done_i), .pll_lock_o(pll_lock_i),
    .new_src_tick_o(new_src_tick_i));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (wdt_clear_o === 1'b1) seen_clr = 1;
    if (cpu_clk_en_o === 1'b0 && sys_clk_en_o === 1'b1) seen_idle = 1;
  end
  // ****
  // Tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic osc_rd(input string nm, input logic [31:0] exp, input logic [31:0] m);
    wb(0, `CSSC_OFS_OSC, 4'hf, 32'h0);
    chk(nm, exp, rd & m);
  endtask
  task automatic req_switch(input logic [2:0] src, input logic [7:0] lo);
    wb(1, `CSSC_OFS_OSC, 4'h2, {16'h0, `CSSC_KEY_H1, 8'h0});
    wb(1, `CSSC_OFS_OSC, 4'h2, {16'h0, `CSSC_KEY_H2, 8'h0});
    wb(1, `CSSC_OFS_OSC, 4'h2, {21'h0, src, 8'h0});
    wb(1, `CSSC_OFS_OSC, 4'h1, {24'h0, `CSSC_KEY_L1});
    wb(1, `CSSC_OFS_OSC, 4'h1, {24'h0, `CSSC_KEY_L2});
    wb(1, `CSSC_OFS_OSC, 4'h1, {24'h0, lo});
  endtask
  task automatic ticks(input int n);
    run <= 1;
    repeat (n) @(posedge new_src_tick_i);
    @(posedge clk_i);
    run <= 0;
  endtask
  task automatic final_report;
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  initial begin
    wt(2);
    rst_i <= 0;
    wt(3);
    osc_rd("osc_reset", 32'h0, 32'h7729);
    wb(0, 8'h10, 4'hf, 32'h0);
    chk("unmapped", 32'h0, rd);
    req_switch(3'h2, 8'h01);
    wt(4);
    osc_rd("req_off", 32'h0, 32'h1);
    chk("sel_off", 3'h0, sys_clk_sel_o);
    clock_switch_cfg_bit_i <= 0;
    wt(4);
    chk("monitor_on", 1'b1, fail_safe_active_o);
    wb(1, `CSSC_OFS_OSC, 4'h2, {16'h0, `CSSC_KEY_H1, 8'h0});
    wb(1, `CSSC_OFS_OSC, 4'h2, 32'h0);
    wb(1, `CSSC_OFS_OSC, 4'h2, {16'h0, `CSSC_KEY_H2, 8'h0});
    wb(1, `CSSC_OFS_OSC, 4'h2, 32'h0500);
    osc_rd("new_locked", 32'h0, 32'h0700);
    req_switch(3'h0, 8'h01);
    wt(3);
    osc_rd("redundant", 32'h0, 32'h1);
    chk("redundant_busy", 1'b0, switch_busy_o);
    clock_fail_i <= 1;
    wt(3);
    clock_fail_i <= 0;
    osc_rd("fail_set", 32'h8, 32'h8);
    req_switch(3'h2, 8'h09);
    osc_rd("flags_clr", 32'h0, 32'h28);
    wt(80);
    chk("wait_ready", 1'b1, switch_busy_o);
    chk("new_osc_on", 1'b1, osc_enable_o[2]);
    chk("cpu_runs", 1'b1, cpu_clk_en_o);
    ticks(9);
    wt(10);
    chk("sel_9", 3'h0, sys_clk_sel_o);
    ticks(1);
    wt(10);
    chk("sel_10", 3'h2, sys_clk_sel_o);
    osc_rd("switched", 32'h2000, 32'h7001);
    chk("old_off", 1'b0, osc_enable_o[0]);
    req_switch(3'h1, 8'h01);
    wt(8);
    ticks(10);
    wt(10);
    chk("sel_pll", 3'h1, sys_clk_sel_o);
    osc_rd("pll_lock", 32'h1120, 32'h7729);
    chk("pri_off", 6'h22, osc_enable_o);
    wb(1, `CSSC_OFS_CTRL, 4'hf, 32'h1);
    seen_clr = 0;
    irq_pending_i <= 1;
    wb(1, `CSSC_OFS_PSAV, 4'hf, 32'h1);
    wt(6);
    irq_pending_i <= 0;
    chk("idle_entered", 1'b1, seen_idle);
    chk("wdt_clr", 1'b1, seen_clr);
    chk("idle_wake", 1'b1, cpu_clk_en_o);
    wb(1, `CSSC_OFS_PSAV, 4'hf, 32'h0);
    wt(1);
    chk("sleep", 1'b0, sys_clk_en_o);
    chk("sleep_osc", 6'h20, osc_enable_o);
    wdt_timeout_i <= 1;
    wt(1);
    wdt_timeout_i <= 0;
    wt(5);
    chk("sleep_wake", 1'b1, sys_clk_en_o);
    chk("same_src", 3'h1, sys_clk_sel_o);
    wb(1, `CSSC_OFS_PSAV, 4'hf, 32'h1);
    wt(1);
    chk("idle_stop", 1'b0, cpu_clk_en_o);
    chk("idle_sys", 1'b1, sys_clk_en_o);
    wdt_timeout_i <= 1;
    wt(1);
    wdt_timeout_i <= 0;
    wt(5);
    chk("idle_wdt_wake", 1'b1, cpu_clk_en_o);
    final_report;
  end
  initial begin
    #20000;
    fail_count++;
    final_report;
  end
endmodule
bind cssc_clock_switch_ctrl cssc_chk u_cssc_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
  .clock_switch_cfg_bit_i, .wdt_timeout_i, .osc_enable_o, .sys_clk_sel_o, .cpu_clk_en_o,
  .sys_clk_en_o, .fail_safe_active_o, .wdt_clear_o, .switch_busy_o);
